// ### src/lsd_pkg.sv
/*
  Constants, register map and mode codes of the status indicator driver.
  Assumes a 100 MHz core clock and a plain strobe register port.
*/
package lsd_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_KHZ = 100000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_KHZ * TICK_MS;
  localparam int PULSE_PERIOD_US = 200;
  localparam int PULSE_DUTY_PCT = 20;
  localparam int PULSE_CYC = PULSE_PERIOD_US * CLK_KHZ / 1000;
  localparam int PULSE_ON_CYC = PULSE_CYC * PULSE_DUTY_PCT / 100;
  localparam logic [4:0] SER_HALF_LAST = 5'h18;

  // ==========================================================
  // Sizes
  localparam int NPORT = 8;
  localparam int NEVT = 4;
  localparam int SER_PER_PORT = 12;
  localparam int NSER = 96;
  localparam logic [6:0] SER_LAST = 7'h5F;

  // Blink half periods and stretch lengths in ms, by rate code
  localparam logic [8:0] BLINK_HALF_MS [4] =
    '{9'h0C8, 9'h064, 9'h032, 9'h019};
  localparam logic [8:0] STRETCH_MS [4] =
    '{9'h032, 9'h064, 9'h0C8, 9'h190};

  // ==========================================================
  // Register map
  localparam logic [4:0] ADR_MODE_HI = 5'h00;
  localparam logic [4:0] ADR_BEH_HI = 5'h01;
  localparam logic [7:0] ADR_CTRL = 8'h10;
  localparam logic [7:0] ADR_STAT = 8'h11;
  localparam int CTRL_RATE = 0;
  localparam int CTRL_PULSE = 2;
  localparam int CTRL_TXONLY = 3;
  localparam int CTRL_CUONLY = 4;
  localparam int BEH_COMB0 = 0;
  localparam int BEH_COMB1 = 1;
  localparam int BEH_STR0 = 2;
  localparam int BEH_STR1 = 3;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [3:0] BEH_RST = 4'h0;

  // ==========================================================
  // Indicator modes
  typedef logic [3:0] lsd_mode_t;
  localparam lsd_mode_t M_LNKACT = 4'h0;
  localparam lsd_mode_t M_L1000 = 4'h1;
  localparam lsd_mode_t M_L100 = 4'h2;
  localparam lsd_mode_t M_L10 = 4'h3;
  localparam lsd_mode_t M_L100_1000 = 4'h4;
  localparam lsd_mode_t M_L10_1000 = 4'h5;
  localparam lsd_mode_t M_L10_100 = 4'h6;
  localparam lsd_mode_t M_DPXCOL = 4'h8;
  localparam lsd_mode_t M_COL = 4'h9;
  localparam lsd_mode_t M_ACT = 4'hA;
  localparam lsd_mode_t M_FAULT = 4'hC;
  localparam lsd_mode_t M_SERIAL = 4'hD;
  localparam lsd_mode_t M_OFF = 4'hE;
  localparam lsd_mode_t M_ON = 4'hF;

endpackage

// ### src/lsd_top.sv
/*
  Per-port status indicator driver for eight ports, two pins each,
  with blink, pulse stretch, power-saving pulsing and serial stream.
  Assumes port status comes from logic on clk; strap pins are async.
*/
// How it works
// - Collision mode: off, flashes on collisions
// - Activity mode flashes; option counts transmit only
// - Fault mode: high normally, low on fault
// - Forced off and forced on modes
// - Pin high means off, low means on
// - Copper-only option hides fiber link
// - Combine adds flashing activity to primary state
// - Combine and flash style held per pin
// - Blink toggles with equal high and low
// - Stretch holds on and off minimum period
// - Rate picks blink 2.5, 5, 10, 20 Hz
// - Rate picks stretch 50 to 400 ms
// - Pulsing modulates lit pins 5 kHz, 20 percent
// - Serial mode only on port zero pin zero
// - Serial data pin0, clock pin1, others normal
// - 96 bits per frame, data on rising clock
// - Serial bits use port pin zero settings
// - Frame order port 0 to 7, twelve bits
// - Link mode: off, on with link, flashes
// - All indicator outputs active low
// - Mode per pin from register or straps
`timescale 1ns/1ps

module lsd_top
  import lsd_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,        // One ms tick
  parameter int PULSE_CYCLES = PULSE_CYC,      // Pulsing period
  parameter int PULSE_ON_CYCLES = PULSE_ON_CYC // Pulsing lit part
) (
  input wire logic clk,                     // Core clock
  input wire logic rst_n,                   // Async reset
  input wire logic [7:0] reg_addr,          // Register address
  input wire logic [15:0] reg_wdata,        // Write data
  input wire logic reg_wr,                  // Write strobe
  input wire logic reg_rd,                  // Read strobe
  output logic [15:0] reg_rdata,            // Read data
  input wire logic [3:0] strap_mode0,       // Default pin0 mode
  input wire logic [3:0] strap_mode1,       // Default pin1 mode
  input wire logic [7:0] link_1000,         // Copper link 1000
  input wire logic [7:0] link_100,          // Copper link 100
  input wire logic [7:0] link_10,           // Copper link 10
  input wire logic [7:0] link_fiber,        // Fiber link up
  input wire logic [7:0] full_duplex,       // Link full duplex
  input wire logic [7:0] collision,         // Collision seen
  input wire logic [7:0] tx_activity,       // Transmit activity
  input wire logic [7:0] rx_activity,       // Receive activity
  input wire logic [7:0] aneg_fault,        // Negotiation fault
  output logic [7:0] indicator_pin0_n,      // First pins, low lit
  output logic [7:0] indicator_pin1_n       // Second pins, low lit
);

  // ==========================================================
  // Mode decode helpers
  function automatic logic lsd_mix(input logic p, input logic c,
                                   input logic s, input logic e);
    return (c & p & s) ? e : p;
  endfunction

  // lv = {fault, fdx, l10, l100, l1000, any}; ev/ef = {col, act}
  function automatic logic lsd_lit(input lsd_mode_t m,
                                   input logic c,
                                   input logic [5:0] lv,
                                   input logic [1:0] ev,
                                   input logic [1:0] ef);
    logic r;
    r = 1'b0;
    case (m)
      M_LNKACT: r = lsd_mix(lv[0], c, ev[0], ef[0]);
      M_L1000: r = lsd_mix(lv[1], c, ev[0], ef[0]);
      M_L100: r = lsd_mix(lv[2], c, ev[0], ef[0]);
      M_L10: r = lsd_mix(lv[3], c, ev[0], ef[0]);
      M_L100_1000: r = lsd_mix(lv[1] | lv[2], c, ev[0], ef[0]);
      M_L10_1000: r = lsd_mix(lv[1] | lv[3], c, ev[0], ef[0]);
      M_L10_100: r = lsd_mix(lv[2] | lv[3], c, ev[0], ef[0]);
      M_DPXCOL: begin
        if (c & lv[0] & ~lv[4] & ev[1]) begin
          r = ef[1];
        end else begin
          r = lv[0] & lv[4];
        end
      end
      M_COL: r = ef[1];
      M_ACT: r = ef[0];
      M_FAULT: r = lv[5];
      M_ON: r = 1'b1;
      default: r = 1'b0; // Off, reserved, serial off port zero
    endcase
    return r;
  endfunction

  // ==========================================================
  // Strap synchroniser and default load
  logic [3:0] s0_meta_reg, s0_sync_reg;
  logic [3:0] s1_meta_reg, s1_sync_reg;
  logic [1:0] strap_cnt_reg;
  logic strap_load;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s0_meta_reg <= 4'h0;
      s0_sync_reg <= 4'h0;
      s1_meta_reg <= 4'h0;
      s1_sync_reg <= 4'h0;
      strap_cnt_reg <= 2'h0;
    end else begin
      s0_meta_reg <= strap_mode0;
      s0_sync_reg <= s0_meta_reg;
      s1_meta_reg <= strap_mode1;
      s1_sync_reg <= s1_meta_reg;
      if (strap_load) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
    end
  end

  assign strap_load = (strap_cnt_reg != 2'h3);

  // ==========================================================
  // Registers
  logic [7:0] mode_reg [NPORT];
  logic [3:0] beh_reg [NPORT];
  logic [4:0] ctrl_reg;
  logic [15:0] rdata_reg;
  logic [2:0] idx;
  logic hit_mode, hit_beh, hit_ctrl, hit_stat;
  logic [15:0] rd_val;

  assign idx = reg_addr[2:0];
  assign hit_mode = (reg_addr[7:3] == ADR_MODE_HI);
  assign hit_beh = (reg_addr[7:3] == ADR_BEH_HI);
  assign hit_ctrl = (reg_addr == ADR_CTRL);
  assign hit_stat = (reg_addr == ADR_STAT);
  assign rd_val = hit_mode ? {8'h00, mode_reg[idx]} :
                  hit_beh ? {12'h000, beh_reg[idx]} :
                  hit_ctrl ? {11'h000, ctrl_reg} :
                  hit_stat ? {indicator_pin1_n, indicator_pin0_n} :
                  16'h0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NPORT; p++) begin
        mode_reg[p] <= {M_OFF, M_OFF};
        beh_reg[p] <= BEH_RST;
      end
      ctrl_reg <= CTRL_RST;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (strap_load) begin
          mode_reg[p] <= {s1_sync_reg, s0_sync_reg};
        end else if (reg_wr && hit_mode && idx == p[2:0]) begin
          mode_reg[p] <= reg_wdata[7:0];
        end
        if (reg_wr && hit_beh && idx == p[2:0]) begin
          beh_reg[p] <= reg_wdata[3:0];
        end
      end
      if (reg_wr && hit_ctrl) begin
        ctrl_reg <= reg_wdata[4:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      rdata_reg <= rd_val;
    end
  end

  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Control fields
  logic [1:0] rate;
  logic pulse_en, tx_only, cu_only;
  logic [8:0] blink_half, stretch_len;

  assign rate = ctrl_reg[CTRL_RATE +: 2];
  assign pulse_en = ctrl_reg[CTRL_PULSE];
  assign tx_only = ctrl_reg[CTRL_TXONLY];
  assign cu_only = ctrl_reg[CTRL_CUONLY];
  assign blink_half = BLINK_HALF_MS[rate];
  assign stretch_len = STRETCH_MS[rate];

  // ==========================================================
  // Millisecond tick, blink phase, pulsing carrier
  logic [16:0] tick_cnt_reg;
  logic tick_reg;
  logic [8:0] blink_cnt_reg;
  logic blink_reg;
  logic [14:0] pwm_cnt_reg;
  logic pwm_on;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 17'h00000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == 17'(TICK_CYCLES - 1));
      if (tick_cnt_reg == 17'(TICK_CYCLES - 1)) begin
        tick_cnt_reg <= 17'h00000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 17'h00001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_reg <= 9'h000;
      blink_reg <= 1'b0;
    end else if (tick_reg) begin
      if (blink_cnt_reg >= blink_half - 9'h001) begin
        blink_cnt_reg <= 9'h000;
        blink_reg <= ~blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_reg <= 15'h0000;
    end else if (pwm_cnt_reg == 15'(PULSE_CYCLES - 1)) begin
      pwm_cnt_reg <= 15'h0000;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 15'h0001;
    end
  end

  assign pwm_on = (pwm_cnt_reg < 15'(PULSE_ON_CYCLES));

  // ==========================================================
  // Events per port: {rx, tx, col, act} and their stretched form
  logic [NPORT*NEVT-1:0] ev_all;
  logic [NPORT*NEVT-1:0] st_all;

  genvar gp, gk;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_ev
      assign ev_all[gp*NEVT +: NEVT] = {rx_activity[gp],
        tx_activity[gp], collision[gp],
        tx_activity[gp] | (rx_activity[gp] & ~tx_only)};
      for (gk = 0; gk < NEVT; gk++) begin : g_st
        logic on_reg, pend_reg;
        logic [8:0] cnt_reg;
        logic ev;
        assign ev = ev_all[gp*NEVT + gk];
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            on_reg <= 1'b0;
            pend_reg <= 1'b0;
            cnt_reg <= 9'h000;
          end else begin
            // Event during the off hold lights once the hold ends
            if (!on_reg && ev && cnt_reg != 9'h000) begin
              pend_reg <= 1'b1;
            end
            if (on_reg && ev) begin
              cnt_reg <= stretch_len;
            end else if (!on_reg && cnt_reg == 9'h000 &&
                         (pend_reg || ev)) begin
              on_reg <= 1'b1;
              pend_reg <= 1'b0;
              cnt_reg <= stretch_len;
            end else if (tick_reg) begin
              // Off only on the tick after the count ends, never short
              if (cnt_reg != 9'h000) begin
                cnt_reg <= cnt_reg - 9'h001;
              end else if (on_reg) begin
                on_reg <= 1'b0;
                cnt_reg <= stretch_len;
              end
            end
          end
        end
        assign st_all[gp*NEVT + gk] = on_reg;
      end
    end
  endgenerate

  // ==========================================================
  // Pin and serial bit evaluation
  logic [7:0] lit0, lit1;
  logic [NSER-1:0] snap;

  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_pin
      logic [5:0] lv;
      logic [3:0] ev, st, ef0, ef1;
      logic [7:0] md;
      logic [3:0] bh;
      logic [11:0] sb;
      assign md = mode_reg[gp];
      assign bh = beh_reg[gp];
      assign ev = ev_all[gp*NEVT +: NEVT];
      assign st = st_all[gp*NEVT +: NEVT];
      assign lv = {aneg_fault[gp], full_duplex[gp], link_10[gp],
                   link_100[gp], link_1000[gp],
                   link_1000[gp] | link_100[gp] | link_10[gp] |
                   (link_fiber[gp] & ~cu_only)};
      assign ef0 = bh[BEH_STR0] ? st : (ev & {4{blink_reg}});
      assign ef1 = bh[BEH_STR1] ? st : (ev & {4{blink_reg}});
      assign lit0[gp] = lsd_lit(md[3:0], bh[BEH_COMB0], lv,
                                ev[1:0], ef0[1:0]);
      assign lit1[gp] = lsd_lit(md[7:4], bh[BEH_COMB1], lv,
                                ev[1:0], ef1[1:0]);
      // Serial bits use pin0 settings of the port
      assign sb = {lv[5], ef0[3], ef0[2], 1'b0,
        lsd_lit(M_ACT, bh[BEH_COMB0], lv, ev[1:0], ef0[1:0]),
        lsd_lit(M_COL, bh[BEH_COMB0], lv, ev[1:0], ef0[1:0]),
        lsd_lit(M_DPXCOL, bh[BEH_COMB0], lv, ev[1:0], ef0[1:0]),
        1'b0,
        lsd_lit(M_L10, bh[BEH_COMB0], lv, ev[1:0], ef0[1:0]),
        lsd_lit(M_L100, bh[BEH_COMB0], lv, ev[1:0], ef0[1:0]),
        lsd_lit(M_L1000, bh[BEH_COMB0], lv, ev[1:0], ef0[1:0]),
        lsd_lit(M_LNKACT, bh[BEH_COMB0], lv, ev[1:0], ef0[1:0])};
      assign snap[gp*SER_PER_PORT +: SER_PER_PORT] = ~sb;
    end
  endgenerate

  // ==========================================================
  // Serial stream engine
  logic ser_on;
  logic [4:0] sdiv_reg;
  logic sclk_reg, sdat_reg;
  logic [6:0] sidx_reg;
  logic [NSER-1:0] sh_reg;

  assign ser_on = (mode_reg[0][3:0] == M_SERIAL);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdiv_reg <= 5'h00;
      sclk_reg <= 1'b0;
      sdat_reg <= 1'b1;
      sidx_reg <= 7'h00;
      sh_reg <= '1;
    end else if (!ser_on) begin
      sdiv_reg <= 5'h00;
      sclk_reg <= 1'b0;
      sdat_reg <= 1'b1;
      sidx_reg <= 7'h00;
      sh_reg <= snap;
    end else if (sdiv_reg == SER_HALF_LAST) begin
      sdiv_reg <= 5'h00;
      sclk_reg <= ~sclk_reg;
      if (!sclk_reg) begin
        sdat_reg <= sh_reg[0];
        if (sidx_reg == SER_LAST) begin
          sidx_reg <= 7'h00;
          sh_reg <= snap;
        end else begin
          sidx_reg <= sidx_reg + 7'h01;
          sh_reg <= sh_reg >> 1;
        end
      end
    end else begin
      sdiv_reg <= sdiv_reg + 5'h01;
    end
  end

  // ==========================================================
  // Output pins, low when lit
  logic [7:0] pin0_next, pin1_next;
  logic gate;

  assign gate = ~pulse_en | pwm_on;
  assign pin0_next = ~(lit0 & {8{gate}});
  assign pin1_next = ~(lit1 & {8{gate}});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      indicator_pin0_n <= 8'hFF;
      indicator_pin1_n <= 8'hFF;
    end else if (ser_on) begin
      indicator_pin0_n <= {pin0_next[7:1], sdat_reg};
      indicator_pin1_n <= {pin1_next[7:1], sclk_reg};
    end else begin
      indicator_pin0_n <= pin0_next;
      indicator_pin1_n <= pin1_next;
    end
  end

endmodule // lsd_top

// ### testbench/led_status_driver_tb.sv
/* Self-checking bench of the status indicator driver with serial sink.
   Assumes package, design, sink model and checker are compiled first. */
`timescale 1ns/1ps
module led_status_driver_tb;
  import lsd_pkg::*;
  localparam int TK = 10;
  localparam logic [15:0] MODE_EXP = 16'h6ECC;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [3:0] strap_mode0 = 4'h1;
  logic [3:0] strap_mode1 = 4'h3;
  logic [7:0] link_1000 = 8'h13, link_100 = 8'h20, link_10 = 8'h40;
  logic [7:0] link_fiber = 8'h00, full_duplex = 8'h23, aneg_fault = 8'h82;
  logic [7:0] collision = 8'h00, tx_activity = 8'h00, rx_activity = 8'h00;
  logic [7:0] pin0_n, pin1_n;
  logic sink_clr = 1'b1;
  logic [95:0] frame;
  int frames, n_fail = 0, total_checks = 0;

  always #5 clk = ~clk;

  lsd_top #(.TICK_CYCLES(TK), .PULSE_CYCLES(50), .PULSE_ON_CYCLES(10))
  lsd_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .strap_mode0(strap_mode0),
    .strap_mode1(strap_mode1), .link_1000(link_1000), .link_100(link_100),
    .link_10(link_10), .link_fiber(link_fiber), .full_duplex(full_duplex),
    .collision(collision), .tx_activity(tx_activity),
    .rx_activity(rx_activity), .aneg_fault(aneg_fault),
    .indicator_pin0_n(pin0_n), .indicator_pin1_n(pin1_n));

  lsd_serial_sink lsd_serial_sink_inst (.sdata(pin0_n[0]),
    .sclk(pin1_n[0]), .clear(sink_clr), .frame(frame), .frames(frames));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [95:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("read data", 96'(reg_rdata), 96'(e));
    @(posedge clk);
  endtask
  task automatic run(input int p, input logic v, input int lim, output int n);
    n = 0;
    #1;
    while (pin0_n[p] === v && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  function automatic logic [11:0] port_bits(input int p);
    logic lk;
    lk = link_1000[p] | link_100[p] | link_10[p] | link_fiber[p];
    return ~{lk, link_1000[p], link_100[p], link_10[p], 1'b0,
             lk & full_duplex[p], 5'h00, aneg_fault[p]};
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(8'h00, 16'h0031);
    rd(ADR_STAT, 16'hBFEC);
    rd(ADR_CTRL, 16'h0000);
    rd(8'h08, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(ADR_CTRL, 16'hFFFF);
    rd(ADR_CTRL, 16'h001F);
    wr(8'h0A, 16'h0005);
    rd(8'h0A, 16'h0005);
    rd(8'h0B, 16'h0000);
    wr(ADR_CTRL, 16'h0000);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 16; m++) begin
      wr(8'h01, {8'h00, 4'hE, 4'(m)});
      tick(2);
      #1 chk("mode pin", 96'(pin0_n[1]), 96'(MODE_EXP[m]));
      chk("off pin", 96'(pin1_n[1]), 96'(1'b1));
    end
    wr(8'h01, 16'h00FF);
    tick(2);
    #1 chk("forced on", 96'({pin1_n[1], pin0_n[1]}), 96'h0);
    link_1000[1] <= 1'b0;
    link_fiber[1] <= 1'b1;
    wr(8'h01, 16'h00E0);
    tick(2);
    #1 chk("fiber link", 96'(pin0_n[1]), 96'(1'b0));
    wr(ADR_CTRL, 16'h0010);
    tick(2);
    #1 chk("copper only", 96'(pin0_n[1]), 96'(1'b1));
    wr(ADR_CTRL, 16'h0000);
    link_1000[1] <= 1'b1;
    link_fiber[1] <= 1'b0;
  endtask
  task automatic t_blink();
    int w, lo, hi;
    wr(8'h02, 16'h00EA);
    wr(8'h0A, 16'h0000);
    tx_activity <= 8'h04;
    for (int r = 0; r < 4; r++) begin
      wr(ADR_CTRL, 16'(r));
      run(2, 1'b0, 5000, w);
      run(2, 1'b1, 5000, w);
      run(2, 1'b0, 5000, lo);
      run(2, 1'b1, 5000, hi);
      chk("blink low", 96'(lo), 96'(BLINK_HALF_MS[r] * TK));
      chk("blink high", 96'(hi), 96'(BLINK_HALF_MS[r] * TK));
    end
    tx_activity <= 8'h00;
    rx_activity <= 8'h04;
    wr(ADR_CTRL, 16'h000B);
    run(2, 1'b1, 600, w);
    chk("tx only", 96'(w), 96'(600));
    wr(ADR_CTRL, 16'h0003);
    run(2, 1'b1, 600, w);
    chk("rx counts", 96'(w < 600), 96'(1));
    rx_activity <= 8'h00;
  endtask
  task automatic t_stretch();
    int w, lo, hi;
    wr(8'h03, 16'h00E9);
    wr(8'h0B, 16'h0004);
    wr(ADR_CTRL, 16'h0000);
    @(posedge clk) collision <= 8'h08;
    @(posedge clk) collision <= 8'h00;
    run(3, 1'b1, 20, w);
    run(3, 1'b0, 2000, lo);
    chk("stretch on", 96'(lo >= 500 && lo <= 510), 96'(1));
    @(posedge clk) collision <= 8'h08;
    @(posedge clk) collision <= 8'h00;
    run(3, 1'b1, 2000, hi);
    chk("stretch off", 96'(hi >= 498 && hi <= 510), 96'(1));
    chk("late event", 96'(pin0_n[3]), 96'(1'b0));
  endtask
  task automatic t_combine();
    int w;
    tx_activity <= 8'h10;
    wr(8'h04, 16'h00E1);
    wr(ADR_CTRL, 16'h0003);
    run(4, 1'b0, 600, w);
    chk("combine off", 96'(w), 96'(600));
    wr(8'h0C, 16'h0001);
    run(4, 1'b0, 600, w);
    chk("combine on", 96'(w < 600), 96'(1));
    tx_activity <= 8'h00;
  endtask
  task automatic t_pulse();
    int n;
    wr(8'h01, 16'h00EF);
    wr(ADR_CTRL, 16'h0004);
    tick(5);
    n = 0;
    repeat (100) begin
      @(posedge clk);
      #1 n += (pin0_n[1] === 1'b0);
    end
    chk("pulsing duty", 96'(n), 96'(20));
    wr(ADR_CTRL, 16'h0000);
  endtask
  task automatic t_serial();
    logic [95:0] e;
    int w;
    for (int p = 0; p < 8; p++) e[95 - 12 * p -: 12] = port_bits(p);
    wr(8'h00, 16'h00ED);
    tick(2);
    sink_clr <= 1'b0;
    w = 0;
    while (frames < 2 && w < 12000) begin
      @(posedge clk);
      w++;
    end
    chk("serial frame", frame, e);
    chk("frame count", 96'(frames), 96'(2));
    chk("other pin", 96'(pin0_n[1]), 96'(1'b0));
    wr(8'h00, 16'h00EE);
    tick(2);
    #1 chk("serial off", 96'({pin1_n[0], pin0_n[0]}), 96'(2'b11));
  endtask

  // ==========================================================
  // Verdict and main sequence
  task automatic summarize();
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #600000;
    n_fail++;
    summarize();
  end

  initial begin
    rst_n <= 1'b0;
    tick(20);
    rst_n <= 1'b1;
    tick(4);
    t_regs();
    t_modes();
    t_blink();
    t_stretch();
    t_combine();
    t_pulse();
    t_serial();
    summarize();
  end
endmodule // led_status_driver_tb

bind lsd_top lsd_top_properties lsd_top_properties_inst (.clk(clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .indicator_pin0_n(indicator_pin0_n), .indicator_pin1_n(indicator_pin1_n));

// ### testbench/lsd_serial_sink.sv
/* Model of external serial indicator shift logic on the stream pins.
   Assumes clear is held high until the stream is enabled. */
`timescale 1ns/1ps
module lsd_serial_sink (
  input wire logic sdata,    // Serial data
  input wire logic sclk,     // Serial clock
  input wire logic clear,    // Restart bit count
  output logic [95:0] frame, // Last frame, bit one at top
  output int frames          // Frames received
);
  logic [95:0] sh;
  int cnt;
  // Sample mid bit, data moves on the rising clock
  always @(negedge sclk or posedge clear) begin
    if (clear) begin
      cnt = 0;
      frames = 0;
    end else begin
      sh = {sh[94:0], sdata};
      cnt++;
      if (cnt == 96) begin
        frame = sh;
        frames++;
        cnt = 0;
      end
    end
  end
endmodule // lsd_serial_sink

// ### testbench/lsd_top_properties.sv
/* Checker of the status indicator driver, seeing only its top ports.
   Assumes one clock domain and no writes in the straps load window. */
`timescale 1ns/1ps
module lsd_top_properties
  import lsd_pkg::*;
(
  input wire logic clk,                    // Core clock
  input wire logic rst_n,                  // Async reset
  input wire logic [7:0] reg_addr,         // Address
  input wire logic [15:0] reg_wdata,       // Write data
  input wire logic reg_wr,                 // Write strobe
  input wire logic reg_rd,                 // Read strobe
  input wire logic [15:0] reg_rdata,       // Read data
  input wire logic [7:0] indicator_pin0_n, // First pins
  input wire logic [7:0] indicator_pin1_n  // Second pins
);
  // ==========================================================
  // Shadow of the pulsing enable
  logic pulse_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pulse_reg <= 1'b0;
    else if (reg_wr && reg_addr == ADR_CTRL) pulse_reg <= reg_wdata[2];
  end

  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_mode_wr(logic [7:0] v);
    reg_wr && reg_addr[7:3] == 5'h00 && reg_wdata[7:0] == v && !pulse_reg
      ##1 !reg_wr;
  endsequence

  force_on_a: assert property (s_mode_wr(8'hFF) |=>
    {indicator_pin0_n[$past(reg_addr[2:0], 2)],
     indicator_pin1_n[$past(reg_addr[2:0], 2)]} == 2'b00)
    else $error("forced on pins not low");
  force_off_a: assert property (s_mode_wr(8'hEE) |=>
    {indicator_pin0_n[$past(reg_addr[2:0], 2)],
     indicator_pin1_n[$past(reg_addr[2:0], 2)]} == 2'b11)
    else $error("forced off pins not high");
  reset_dark_a: assert property (disable iff (1'b0)
    !$past(rst_n) && !rst_n |-> {indicator_pin1_n, indicator_pin0_n} == 16'hFFFF)
    else $error("pins lit in reset");
  rd_status_a: assert property (reg_rd && reg_addr == ADR_STAT |=>
    reg_rdata == $past({indicator_pin1_n, indicator_pin0_n}))
    else $error("status read differs from pins");
  rd_unmapped_a: assert property (reg_rd && reg_addr > ADR_STAT |=>
    reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  mode_width_a: assert property (reg_rd && reg_addr < 8'h08 |=>
    reg_rdata[15:8] == 8'h00)
    else $error("mode read upper bits set");
  beh_width_a: assert property (reg_rd && reg_addr[7:3] == 5'h01 |=>
    reg_rdata[15:4] == 12'h000)
    else $error("behaviour read upper bits set");
  ctrl_width_a: assert property (reg_rd && reg_addr == ADR_CTRL |=>
    reg_rdata[15:5] == 11'h000)
    else $error("control read upper bits set");
endmodule // lsd_top_properties
